// ### inc/tw_master_pkg.sv
// Constants and types shared by the two-wire bus master and its helpers.
// Assumes a 50 MHz system clock and an external pull-up on both bus wires.
package tw_master_pkg;

  // System clock period
  localparam int CLK_NS = 20;

  // Bus clock periods for standard (100 kHz) and fast (400 kHz) mode
  localparam int STD_PERIOD_NS = 10000;
  localparam int FAST_PERIOD_NS = 2500;

  // Quarter of a bus clock period in system cycles, rounded up so SCL never runs fast
  localparam int QTR_STD_CYC = (STD_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int QTR_FAST_CYC = (FAST_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);

  // Address byte layout: identifier [7:4], select bits [3:1], direction [0]
  localparam int BYTE_W = 8;
  localparam int SEL_W = 3;
  localparam int DIR_POS = 0;
  localparam int SEL_POS = 1;
  localparam int ID_POS = 4;
  // Fixed identifier field of the target; value is arbitrary
  localparam logic [3:0] DEV_ID_FIELD = 4'h5;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // Index of the acknowledge bit within a nine-bit byte slot
  localparam logic [3:0] ACK_IDX = 4'h8;

  // Commands accepted on the user port
  typedef enum logic [2:0] {
    OP_START = 3'b000,
    OP_ADDR = 3'b001,
    OP_WRITE = 3'b010,
    OP_READ = 3'b011,
    OP_STOP = 3'b100
  } op_e;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_HELD = 3'b010,
    ST_BIT = 3'b011,
    ST_STOP = 3'b100
  } state_e;

endpackage : tw_master_pkg

// ### design/pin_sync.sv
// Two-flop synchroniser for bus wires sampled by the system clock.
// Assumes inputs are asynchronous pins; only the second stage is read.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [W-1:0] pin_in, // Raw pin levels
  output logic [W-1:0] pin_sync // Synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  if (W < 1) begin : g_bad_w
    $error("pin_sync needs at least one bit");
  end

  // Idle bus level is high, so reset to ones to avoid a false busy reading
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;

endmodule : pin_sync

// ### design/qtr_divider.sv
// Quarter-period tick generator for the bus clock.
// Assumes the sequencer restarts it with clear whenever a command is taken.
`timescale 1ns/100ps
module qtr_divider
  import tw_master_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clear, // Restart the quarter count
  input wire logic fast, // 1 selects fast mode
  output logic tick // One-cycle pulse at the end of each quarter
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire [CNT_W-1:0] last_std = CNT_W'(QTR_STD_CYC - 1);
  wire [CNT_W-1:0] last_fast = CNT_W'(QTR_FAST_CYC - 1);
  wire [CNT_W-1:0] last_cnt = fast ? last_fast : last_std;

  if (QTR_STD_CYC >= (1 << CNT_W) || QTR_FAST_CYC < 2) begin : g_bad_cnt
    $error("qtr_divider counter width cannot hold a quarter period");
  end

  // Quarter length sets the bus rate in either mode
  assign tick = (cnt_r == last_cnt) && !clear;
  assign cnt_nxt = (clear || tick) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  tick_gap_a: assert property (@(posedge clock) disable iff (rst)
    tick |=> !tick [*8])
    else $error("quarter ticks closer than eight cycles");

endmodule : qtr_divider

// ### design/tw_master.sv
// Two-wire bus master that drives a slave clock generator through SDA and SCL.
// Assumes open-drain wires with pull-ups resolved outside; the bus clock is made here.
// What this block does
// - Start a transfer only on idle bus.
// - SDA steady while SCL high, except conditions.
// - SDA falling, SCL high, is START.
// - SDA rising, SCL high, is STOP.
// - Change SDA on SCL low; one pulse/bit.
// - Transfers open with START, close with STOP.
// - Eight-bit bytes plus ninth acknowledge clock.
// - Target acks writes; master clocks the ack.
// - Acker holds SDA low through ack high.
// - Master NACKs last read byte; target releases.
// - Write sends address byte, then data bytes.
// - Read: master acks all but last byte.
`timescale 1ns/100ps
module tw_master
  import tw_master_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clock, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic fast_mode, // 1 for 400 kHz, 0 for 100 kHz
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Command can be taken
  input wire logic [2:0] cmd_op, // Command code, op_e
  input wire logic [7:0] cmd_data, // Byte to write
  input wire logic [2:0] cmd_sel, // Target select bits for an address byte
  input wire logic cmd_dir, // Direction for an address byte, 1 is read
  input wire logic cmd_last, // Read: last byte, answer with not-acknowledge
  output logic rsp_valid, // Command finished, one-cycle pulse
  output logic [7:0] rsp_data, // Byte seen on the bus
  output logic rsp_nack, // Acknowledge slot was high
  output logic rsp_err, // Command refused in this state
  output logic busy, // Bus is held by this master
  input wire logic scl_i, // SCL wire level
  output logic scl_o, // SCL output value, always low
  output logic scl_oe, // SCL pull-down enable
  input wire logic sda_i, // SDA wire level
  output logic sda_o, // SDA output value, always low
  output logic sda_oe // SDA pull-down enable
);

  state_e state_r, state_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic read_r, read_nxt;
  logic last_r, last_nxt;
  logic nack_r, nack_nxt;
  logic scl_drv_r, scl_drv_nxt;
  logic sda_drv_r, sda_drv_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [7:0] rsp_data_r, rsp_data_nxt;
  logic rsp_nack_r, rsp_nack_nxt;
  logic rsp_err_r, rsp_err_nxt;
  logic [1:0] wire_sync;
  logic tick;

  // Bus wires come from another domain, so both pass two flops first
  pin_sync #(
    .W(2)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in({scl_i, sda_i}),
    .pin_sync(wire_sync)
  );

  wire scl_s = wire_sync[1];
  wire sda_s = wire_sync[0];
  wire bus_idle = scl_s && sda_s;

  // In idle every command waits for an idle bus; a held bus takes any command
  wire in_idle = (state_r == ST_IDLE);
  wire in_held = (state_r == ST_HELD);
  assign cmd_ready = in_held || (in_idle && bus_idle);
  wire take = cmd_valid && cmd_ready;
  wire op_start = (cmd_op == OP_START);
  wire op_addr = (cmd_op == OP_ADDR);
  wire op_write = (cmd_op == OP_WRITE);
  wire op_read = (cmd_op == OP_READ);
  wire op_stop = (cmd_op == OP_STOP);
  wire op_known = op_start || op_addr || op_write || op_read || op_stop;
  wire [7:0] addr_byte = {DEV_ID_FIELD, cmd_sel, cmd_dir};
  wire [7:0] tx_byte = op_addr ? addr_byte : cmd_data;
  wire is_ack_bit = (bit_r == ACK_IDX);

  // Quarter ticks pace every wire change after the taking edge; restarted on each taken command
  qtr_divider #(
    .CNT_W(CNT_W)
  ) u_div (
    .clock(clock),
    .rst(rst),
    .clear(take),
    .fast(fast_mode),
    .tick(tick)
  );

  // Sequencer: each bus clock is four quarters, SCL low in q0-q1 and high in q2-q3
  always_comb begin
    state_nxt = state_r;
    q_nxt = q_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    read_nxt = read_r;
    last_nxt = last_r;
    nack_nxt = nack_r;
    scl_drv_nxt = scl_drv_r;
    sda_drv_nxt = sda_drv_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    rsp_nack_nxt = rsp_nack_r;
    rsp_err_nxt = 1'b0;
    if (take) begin
      q_nxt = 2'h0;
      bit_nxt = 4'h0;
    end
    case (state_r)
      ST_IDLE: begin
        scl_drv_nxt = 1'b0;
        sda_drv_nxt = 1'b0;
        if (take && op_start) begin
          state_nxt = ST_START;
        end else if (take) begin
          rsp_valid_nxt = 1'b1;
          rsp_err_nxt = 1'b1;
        end
      end
      ST_HELD: begin
        // SCL stays low here, so SDA may be set up for whatever comes next
        if (take && op_start) begin
          state_nxt = ST_START;
          sda_drv_nxt = 1'b0;
        end else if (take && op_stop) begin
          state_nxt = ST_STOP;
          sda_drv_nxt = 1'b1;
        end else if (take && (op_addr || op_write)) begin
          state_nxt = ST_BIT;
          sh_nxt = tx_byte;
          read_nxt = 1'b0;
          sda_drv_nxt = !tx_byte[7];
        end else if (take && op_read) begin
          state_nxt = ST_BIT;
          sh_nxt = 8'h00;
          read_nxt = 1'b1;
          last_nxt = cmd_last;
          sda_drv_nxt = 1'b0;
        end else if (take && !op_known) begin
          rsp_valid_nxt = 1'b1;
          rsp_err_nxt = 1'b1;
        end
      end
      ST_START: begin
        if (tick) begin
          q_nxt = q_r + 2'h1;
          case (q_r)
            2'h0: scl_drv_nxt = 1'b0;
            2'h1: sda_drv_nxt = 1'b1;
            2'h2: scl_drv_nxt = 1'b1;
            default: begin
              state_nxt = ST_HELD;
              rsp_valid_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          q_nxt = q_r + 2'h1;
          case (q_r)
            2'h0: scl_drv_nxt = 1'b0;
            2'h1: sda_drv_nxt = 1'b0;
            2'h2: state_nxt = ST_STOP;
            default: begin
              state_nxt = ST_IDLE;
              rsp_valid_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_BIT: begin
        if (tick) begin
          q_nxt = q_r + 2'h1;
          case (q_r)
            2'h0: begin
              // SCL has been low a full quarter, so SDA moves well clear of its falling edge
              if (is_ack_bit) begin
                sda_drv_nxt = read_r && !last_r;
              end else begin
                sda_drv_nxt = !read_r && !sh_r[7];
              end
            end
            2'h1: scl_drv_nxt = 1'b0;
            2'h2: begin
              // Sample in the middle of the high phase
              if (is_ack_bit) begin
                nack_nxt = sda_s;
              end else begin
                sh_nxt = {sh_r[6:0], sda_s};
              end
            end
            default: begin
              scl_drv_nxt = 1'b1;
              if (is_ack_bit) begin
                state_nxt = ST_HELD;
                rsp_valid_nxt = 1'b1;
                rsp_data_nxt = sh_r;
                rsp_nack_nxt = nack_r;
              end else if (bit_r == 4'h7) begin
                bit_nxt = ACK_IDX;
              end else begin
                bit_nxt = bit_r + 4'h1;
              end
            end
          endcase
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        scl_drv_nxt = 1'b0;
        sda_drv_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      read_r <= 1'b0;
      last_r <= 1'b0;
      nack_r <= 1'b0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      read_r <= read_nxt;
      last_r <= last_nxt;
      nack_r <= nack_nxt;
      scl_drv_r <= scl_drv_nxt;
      sda_drv_r <= sda_drv_nxt;
    end
  end

  // Answer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_nack_r <= 1'b0;
      rsp_err_r <= 1'b0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      rsp_nack_r <= rsp_nack_nxt;
      rsp_err_r <= rsp_err_nxt;
    end
  end

  // Open-drain: the pins only ever pull low; the pull-up makes the high level
  assign scl_o = 1'b0;
  assign scl_oe = scl_drv_r;
  assign sda_o = 1'b0;
  assign sda_oe = sda_drv_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_nack = rsp_nack_r;
  assign rsp_err = rsp_err_r;
  assign busy = !in_idle;

  sda_stable_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BIT && !scl_drv_r) |-> $stable(sda_drv_r))
    else $error("SDA moved while SCL high inside a bit");

  sda_move_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BIT && $changed(sda_drv_r)) |-> (scl_drv_r && $past(scl_drv_r)))
    else $error("SDA changed while SCL not held low");

  start_only_a: assert property (@(posedge clock) disable iff (rst)
    ($rose(sda_drv_r) && !$past(scl_drv_r)) |-> (state_r == ST_START && q_r == 2'h2))
    else $error("SDA pulled low with SCL high outside START");

  stop_only_a: assert property (@(posedge clock) disable iff (rst)
    ($fell(sda_drv_r) && !$past(scl_drv_r)) |-> (state_r == ST_STOP && q_r == 2'h2))
    else $error("SDA released with SCL high outside STOP");

  ack_drive_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BIT && is_ack_bit && read_r && !last_r && q_r != 2'h0) |-> sda_drv_r)
    else $error("master acknowledge not held low");

  last_nack_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_BIT && is_ack_bit && read_r && last_r) |-> !sda_drv_r)
    else $error("last read byte not answered with not-acknowledge");

  idle_begin_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_START && q_r == 2'h1 && tick) |-> bus_idle)
    else $error("START begun on a busy bus");

  addr_layout_a: assert property (@(posedge clock) disable iff (rst)
    (in_held && take && op_addr) |=>
      (sh_r[DIR_POS] == $past(cmd_dir) && sh_r[7:ID_POS] == DEV_ID_FIELD &&
       sh_r[ID_POS-1:SEL_POS] == $past(cmd_sel)))
    else $error("address byte layout wrong");

  scl_high_len_a: assert property (@(posedge clock) disable iff (rst)
    ($fell(scl_drv_r) && state_r == ST_BIT) |-> (!scl_drv_r) [*8])
    else $error("SCL high phase too short");

  ninth_clock_a: assert property (@(posedge clock) disable iff (rst)
    (rsp_valid_nxt && state_r == ST_BIT) |-> (is_ack_bit && q_r == 2'h3))
    else $error("byte finished before its ninth clock");

endmodule : tw_master

// ### verification/tw_slave_model.sv
// Behavioural model of the slave clock generator's two-wire port.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/100ps
module tw_slave_model
  import tw_master_pkg::*;
#(
  parameter logic [2:0] SEL = 3'h2, // Own select bits
  parameter logic [7:0] RD_BASE = 8'h96 // First byte sent in a read
) (
  input wire logic scl, // SCL wire level
  input wire logic sda, // SDA wire level
  input wire logic store_busy, // EEPROM store in progress
  output logic sda_oe, // High pulls SDA low
  output logic [7:0] rx_last // Last data byte taken in a write
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic act, fst, rd, adr, done;

  // Quiet until the first START
  initial begin
    sda_oe = 1'b0;
    rx_last = 8'h00;
    act = 1'b0;
    rd = 1'b0;
    adr = 1'b0;
  end

  // START and repeated START both reopen the transfer; count starts at -1
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    fst = 1'b1;
    adr = 1'b0;
    done = 1'b0;
    cnt = 4'hf;
    tx = RD_BASE;
    sda_oe = 1'b0;
  end

  // STOP ends the transfer and leaves the bus idle
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end

  // Sample in the high phase only, whatever the SCL rate
  always @(posedge scl) if (act) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    else if (rd && adr && !fst && sda) done = 1'b1;
  end

  // Change SDA only after SCL falls; SCL itself is never driven
  always @(negedge scl) if (act) begin
    cnt = cnt + 4'h1;
    if (cnt == 4'h8 && fst) begin
      adr = (sh[7:1] === {DEV_ID_FIELD, SEL}) && !store_busy;
      rd = sh[0];
    end
    if (cnt == 4'h8 && !fst && adr && !rd) rx_last = sh;
    if (cnt == 4'h9) begin
      cnt = 4'h0;
      if (!fst && rd) tx = tx + 8'h01;
      fst = 1'b0;
    end
    // Busy store or foreign address leaves adr low, so SDA stays released
    if (cnt == 4'h8) sda_oe = adr && (fst || !rd);
    else sda_oe = adr && rd && !fst && !done && !tx[3'h7 - cnt[2:0]];
  end
endmodule : tw_slave_model

// ### verification/tb.sv
// Self-checking bench: two-wire master driving the slave model.
// Assumes the package, design files and slave model are compiled first.
`timescale 1ns/100ps
module tb;
  import tw_master_pkg::*;
  logic clock, rst, fast_mode, cmd_valid, cmd_dir, cmd_last, store_busy;
  logic [2:0] cmd_op;
  logic [2:0] cmd_sel;
  logic [7:0] cmd_data, rsp_data, r_data, rx_last;
  logic cmd_ready, rsp_valid, rsp_nack, rsp_err, busy, r_nack, r_err;
  logic scl_o, scl_oe, sda_o, sda_oe, slv_oe;
  wire logic scl_w;
  wire logic sda_w;
  int err_total, cmp_count;

  // Open-drain wires with pull-ups
  assign scl_w = scl_oe ? scl_o : 1'b1;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & !slv_oe;

  tw_master dut_u (
    .clock(clock), .rst(rst), .fast_mode(fast_mode), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_sel(cmd_sel),
    .cmd_dir(cmd_dir), .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack), .rsp_err(rsp_err), .busy(busy), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );

  tw_slave_model #(.SEL(3'h2), .RD_BASE(8'h96)) slv_u (
    .scl(scl_w), .sda(sda_w), .store_busy(store_busy), .sda_oe(slv_oe), .rx_last(rx_last)
  );

  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Offer one command, hold it to the taking edge, then wait for its answer
  task automatic cmd(input op_e op, input logic [7:0] d, input logic [2:0] s,
                     input logic dr, input logic lst);
    int n;
    n = 0;
    cmd_op = op;
    cmd_data = d;
    cmd_sel = s;
    cmd_dir = dr;
    cmd_last = lst;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 6000) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 6000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 6000) begin
      err_total++;
      $display("Error cmd_wait expected answer seen timeout");
    end
    r_data = rsp_data;
    r_nack = rsp_nack;
    r_err = rsp_err;
    // One spare cycle keeps the next offer out of this time step
    @(posedge clock);
    #1;
  endtask : cmd

  // START then address byte, judging the address acknowledge
  task automatic open_t(input logic [2:0] s, input logic dr, input logic exp_nack);
    cmd(OP_START, 8'h00, 3'h0, 1'b0, 1'b0);
    chk("start_err", 8'h00, {7'h0, r_err});
    chk("busy_open", 8'h01, {7'h0, busy});
    cmd(OP_ADDR, 8'h00, s, dr, 1'b0);
    chk("addr_byte", {DEV_ID_FIELD, s, dr}, r_data);
    chk("addr_nack", {7'h0, exp_nack}, {7'h0, r_nack});
  endtask : open_t

  // STOP must leave both wires high and the master idle
  task automatic close_t();
    cmd(OP_STOP, 8'h00, 3'h0, 1'b0, 1'b0);
    chk("bus_idle", 8'h03, {6'h0, scl_w, sda_w});
    chk("busy", 8'h00, {7'h0, busy});
  endtask : close_t

  task automatic t_refuse();
    cmd(OP_WRITE, 8'h55, 3'h0, 1'b0, 1'b0);
    chk("idle_write_err", 8'h01, {7'h0, r_err});
  endtask : t_refuse

  // Fast mode write, two data bytes with an unknown command refused between them
  task automatic t_write();
    fast_mode = 1'b1;
    open_t(3'h2, DIR_WRITE, 1'b0);
    cmd(OP_WRITE, 8'h3c, 3'h0, 1'b0, 1'b0);
    chk("wr1_nack", 8'h00, {7'h0, r_nack});
    chk("wr1_rx", 8'h3c, rx_last);
    chk("wr1_echo", 8'h3c, r_data);
    cmd(op_e'(3'h5), 8'h00, 3'h0, 1'b0, 1'b0);
    chk("held_unknown_err", 8'h01, {7'h0, r_err});
    cmd(OP_WRITE, 8'hc3, 3'h0, 1'b0, 1'b0);
    chk("wr2_nack", 8'h00, {7'h0, r_nack});
    chk("wr2_rx", 8'hc3, rx_last);
    close_t();
  endtask : t_write

  // Standard mode: write address, repeated START, read two bytes
  task automatic t_read();
    fast_mode = 1'b0;
    open_t(3'h2, DIR_WRITE, 1'b0);
    open_t(3'h2, DIR_READ, 1'b0);
    cmd(OP_READ, 8'h00, 3'h0, 1'b0, 1'b0);
    chk("rd1_data", 8'h96, r_data);
    chk("rd1_ack", 8'h00, {7'h0, r_nack});
    cmd(OP_READ, 8'h00, 3'h0, 1'b0, 1'b1);
    chk("rd2_data", 8'h97, r_data);
    chk("rd2_nack", 8'h01, {7'h0, r_nack});
    close_t();
  endtask : t_read

  // Foreign select bits: no acknowledge for address or data
  task automatic t_miss();
    fast_mode = 1'b1;
    open_t(3'h5, DIR_WRITE, 1'b1);
    cmd(OP_WRITE, 8'ha5, 3'h0, 1'b0, 1'b0);
    chk("miss_wr_nack", 8'h01, {7'h0, r_nack});
    close_t();
  endtask : t_miss

  // EEPROM store in progress refuses, then normal answers resume
  task automatic t_busy();
    store_busy = 1'b1;
    open_t(3'h2, DIR_WRITE, 1'b1);
    close_t();
    store_busy = 1'b0;
    open_t(3'h2, DIR_WRITE, 1'b0);
    close_t();
  endtask : t_busy

  // Main sequence
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    fast_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_data = 8'h00;
    cmd_sel = 3'h0;
    cmd_dir = 1'b0;
    cmd_last = 1'b0;
    store_busy = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    t_refuse();
    t_write();
    t_read();
    t_miss();
    t_busy();
    finish_test();
  end

  // Watchdog: the tests need about 29000 cycles
  initial begin
    repeat (80000) @(posedge clock);
    err_total++;
    $display("Error watchdog expected end seen timeout");
    finish_test();
  end
endmodule : tb
